// [dtr_regs.vh]
`ifndef DTR_REGS_VH
`define DTR_REGS_VH

// register indexes, byte address is four times the index
`define DTR_IDX_REM1 8'h25
`define DTR_IDX_LOCAL 8'h26
`define DTR_IDX_REM2 8'h27
`define DTR_IDX_EXT 8'h77
`define DTR_IDX_CFG 8'h7d
`define DTR_IDX_STAT 8'h7e
`define DTR_IDX_MSB 9
`define DTR_IDX_LSB 2

// configuration fields and reset value
`define DTR_CFG_FMT_BIT 0
`define DTR_CFG_RUN_BIT 1
`define DTR_CFG_RST 8'h02

// fraction bit positions inside the shared extension register
`define DTR_EXT_REM1_LSB 2
`define DTR_EXT_LOCAL_LSB 4
`define DTR_EXT_REM2_LSB 6

// status fields
`define DTR_STAT_FRZ_BIT 0
`define DTR_STAT_FLT_LSB 1
`define DTR_STAT_VLD_LSB 4

// result codes
`define DTR_TWOS_FAULT 8'h80
`define DTR_TWOS_MIN 8'h81
`define DTR_OFS_FAULT 8'h00
`define DTR_OFS_MIN 8'h01
`define DTR_OFS_MAX 8'hff
`define DTR_OFS_BIAS 9'h040

// channel and excitation codes
`define DTR_CH_LOCAL 2'h0
`define DTR_CH_REM1 2'h1
`define DTR_CH_REM2 2'h2
`define DTR_EXC_OFF 2'h0
`define DTR_EXC_BASE 2'h1
`define DTR_EXC_N1 2'h2
`define DTR_EXC_N2 2'h3

// averaging and timing
`define DTR_AVG_LAST 4'hf
`define DTR_CLK_NS 10
`define DTR_PHASE_NS 2000
`define DTR_PHASE_CYC ((`DTR_PHASE_NS + `DTR_CLK_NS - 1) / `DTR_CLK_NS)

`endif

// [dtr_seq.v]
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.vh"

module dtr_seq (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire adc_valid,
  output reg conv_start,
  output reg [1:0] chan_reg,
  output reg [1:0] exc_reg
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_BASE1 = 3'd1;
  localparam [2:0] ST_MULT1 = 3'd2;
  localparam [2:0] ST_BASE2 = 3'd3;
  localparam [2:0] ST_MULT2 = 3'd4;
  localparam [2:0] ST_CONV = 3'd5;
  localparam [2:0] ST_WAIT = 3'd6;
  localparam [15:0] PHASE_LAST = `DTR_PHASE_CYC - 1;

  reg [2:0] state_reg;
  reg [15:0] tmr_reg;
  wire tmr_done = (tmr_reg == PHASE_LAST);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      tmr_reg <= 16'h0000;
      conv_start <= 1'b0;
      chan_reg <= `DTR_CH_LOCAL;
      exc_reg <= `DTR_EXC_OFF;
    end
    else
    begin
      conv_start <= 1'b0;
      tmr_reg <= tmr_done ? 16'h0000 : tmr_reg + 16'h0001;
      case (state_reg)
        ST_IDLE:
        begin
          tmr_reg <= 16'h0000;
          if (run)
          begin
            state_reg <= (chan_reg == `DTR_CH_LOCAL) ? ST_CONV : ST_BASE1;
            exc_reg <= (chan_reg == `DTR_CH_LOCAL) ? `DTR_EXC_OFF : `DTR_EXC_BASE;
          end
        end
        // base, first multiple, base, second multiple
        ST_BASE1: if (tmr_done) begin state_reg <= ST_MULT1; exc_reg <= `DTR_EXC_N1; end // RULE9
        ST_MULT1: if (tmr_done) begin state_reg <= ST_BASE2; exc_reg <= `DTR_EXC_BASE; end // RULE9
        ST_BASE2: if (tmr_done) begin state_reg <= ST_MULT2; exc_reg <= `DTR_EXC_N2; end // RULE9
        ST_MULT2: if (tmr_done) begin state_reg <= ST_CONV; exc_reg <= `DTR_EXC_OFF; end // RULE9
        ST_CONV:
        begin
          conv_start <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (adc_valid)
          begin
            state_reg <= ST_IDLE;
            chan_reg <= (chan_reg == `DTR_CH_REM2) ? `DTR_CH_LOCAL : chan_reg + 2'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// [dtr_avg.v]
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.vh"

module dtr_avg (
  input wire pclk,
  input wire presetn,
  input wire adc_valid,
  input wire [1:0] chan,
  input wire [9:0] adc_data,
  input wire adc_fault,
  output wire [29:0] avg_bus,
  output wire [2:0] avg_fault,
  output wire [2:0] avg_stb
);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_ch
      localparam [1:0] CH = gi;
      reg [13:0] acc_reg;
      reg [3:0] cnt_reg;
      reg flt_reg;
      reg [9:0] out_reg;
      reg oflt_reg;
      reg stb_reg;
      wire hit = adc_valid && (chan == CH);
      wire [13:0] sum = acc_reg + {{4{adc_data[9]}}, adc_data};
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          acc_reg <= 14'h0000;
          cnt_reg <= 4'h0;
          flt_reg <= 1'b0;
          out_reg <= 10'h000;
          oflt_reg <= 1'b0;
          stb_reg <= 1'b0;
        end
        else
        begin
          stb_reg <= 1'b0;
          if (hit)
          begin
            if (cnt_reg == `DTR_AVG_LAST)
            begin
              // sixteen samples summed, divide by sixteen
              out_reg <= sum[13:4]; // RULE10
              oflt_reg <= flt_reg | adc_fault;
              stb_reg <= 1'b1;
              acc_reg <= 14'h0000;
              flt_reg <= 1'b0;
              cnt_reg <= 4'h0;
            end
            else
            begin
              acc_reg <= sum; // RULE10
              flt_reg <= flt_reg | adc_fault;
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
      end
      assign avg_bus[gi*10 +: 10] = out_reg;
      assign avg_fault[gi] = oflt_reg;
      assign avg_stb[gi] = stb_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// [dtr_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.vh"

// Behaviour
// RULE1: ten-bit converter, quarter degree resolution
// RULE2: local integer byte at index 0x26
// RULE3: offset-64 or twos complement selectable
// RULE4: twos complement integer, 0x80 means fault
// RULE5: offset-64 byte is degrees plus 64, zero faults
// RULE6: offset-64 spans -64 to +191 degrees; the code gives -63 (0x01) to +127 (0xbf)
// RULE7: quarter-degree bits in shared register 0x77
// RULE8: remote results ten-bit twos complement
// RULE9: excite base/N1, then base/N2 per measurement
// RULE10: average sixteen measurements before update
// RULE11: reading 0x77 freezes results until all read
// RULE12: one format for all, applied at write
module dtr_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire conv_start,
  output wire [1:0] conv_chan,
  output wire [1:0] exc_sel,
  input wire adc_valid,
  input wire [9:0] adc_data,
  input wire adc_fault
);

  // averaged converter output, one per sixteen conversions of a channel
  wire [29:0] avg_bus;
  wire [2:0] avg_fault;
  wire [2:0] avg_stb;

  reg [7:0] cfg_reg;
  wire [2:0] pend_bus;
  wire [23:0] int_bus;
  wire [5:0] frac_bus;
  wire [2:0] flt_bus;
  wire [2:0] seen_bus;

  wire fmt_ofs = cfg_reg[`DTR_CFG_FMT_BIT];
  wire run = cfg_reg[`DTR_CFG_RUN_BIT];

  dtr_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .adc_valid(adc_valid),
    .conv_start(conv_start),
    .chan_reg(conv_chan),
    .exc_reg(exc_sel)
  );

  dtr_avg u_avg (
    .pclk(pclk),
    .presetn(presetn),
    .adc_valid(adc_valid),
    .chan(conv_chan),
    .adc_data(adc_data),
    .adc_fault(adc_fault),
    .avg_bus(avg_bus),
    .avg_fault(avg_fault),
    .avg_stb(avg_stb)
  );

  // apb decode
  wire [7:0] idx = paddr[`DTR_IDX_MSB:`DTR_IDX_LSB];
  wire setup_ph = psel && !penable;
  wire setup_rd = setup_ph && !pwrite;
  wire acc_ph = psel && penable;
  wire acc_rd = acc_ph && !pwrite;
  wire hit_rem1 = (idx == `DTR_IDX_REM1);
  wire hit_local = (idx == `DTR_IDX_LOCAL);
  wire hit_rem2 = (idx == `DTR_IDX_REM2);
  wire hit_ext = (idx == `DTR_IDX_EXT);
  wire hit_cfg = (idx == `DTR_IDX_CFG);
  wire hit_stat = (idx == `DTR_IDX_STAT);
  wire hit_res = hit_rem1 | hit_local | hit_rem2;
  wire hit_ro = hit_res | hit_ext | hit_stat;
  wire aligned = (paddr[`DTR_IDX_LSB-1:0] == 2'h0);
  wire in_page = (paddr[11:`DTR_IDX_MSB+1] == 2'h0);
  wire mapped = (hit_ro | hit_cfg) && aligned && in_page;
  wire ro_write = pwrite && hit_ro;
  wire bad = !mapped || ro_write;

  assign pready = acc_ph;
  assign pslverr = acc_ph && bad;

  // twos complement form, 0x80 kept for a faulty diode
  function [9:0] twos_fn;
    input [9:0] raw;
    input flt;
    begin
      if (flt)
        twos_fn = {`DTR_TWOS_FAULT, 2'h0}; // RULE4
      else if (raw[9:2] == `DTR_TWOS_FAULT)
        twos_fn = {`DTR_TWOS_MIN, 2'h0}; // RULE4
      else
        twos_fn = raw; // RULE4 RULE8
    end
  endfunction

  // offset-64 form, all zeros kept for a faulty diode
  function [9:0] ofs_fn;
    input [9:0] raw;
    input flt;
    reg [8:0] biased;
    begin
      biased = {raw[9], raw[9:2]} + `DTR_OFS_BIAS;
      if (flt)
        ofs_fn = {`DTR_OFS_FAULT, 2'h0}; // RULE5
      else if (biased[8] || (biased[7:0] == `DTR_OFS_FAULT))
        ofs_fn = {`DTR_OFS_MIN, 2'h0}; // RULE6
      else
        ofs_fn = {biased[7:0], raw[1:0]}; // RULE5 RULE6
    end
  endfunction

  // one format for every channel, applied where the result registers load
  function [9:0] fmt_fn;
    input [9:0] raw;
    input flt;
    input ofs;
    begin
      if (ofs)
        fmt_fn = ofs_fn(raw, flt); // RULE3
      else
        fmt_fn = twos_fn(raw, flt); // RULE3
    end
  endfunction

  // freeze tracking: fraction read arms, channel reads release
  wire arm = setup_rd && hit_ext && mapped;
  wire [2:0] rd_ch;
  assign rd_ch[`DTR_CH_LOCAL] = acc_rd && hit_local && mapped;
  assign rd_ch[`DTR_CH_REM1] = acc_rd && hit_rem1 && mapped;
  assign rd_ch[`DTR_CH_REM2] = acc_rd && hit_rem2 && mapped;

  // also holds at the setup edge of the arming read
  wire frozen = (pend_bus != 3'h0) || arm; // RULE11

  // per channel result path, slice index is the channel code
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_res
      reg [9:0] raw_reg;
      reg flt_reg;
      reg seen_reg;
      reg [7:0] int_reg;
      reg [1:0] frac_reg;
      reg pend_reg;
      wire [9:0] fmt = fmt_fn(raw_reg, flt_reg, fmt_ofs); // RULE3 RULE12
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          raw_reg <= 10'h000;
          flt_reg <= 1'b0;
          seen_reg <= 1'b0;
        end
        else if (avg_stb[gi])
        begin
          // ten-bit averaged converter result
          raw_reg <= avg_bus[gi*10 +: 10]; // RULE1 RULE8 RULE10
          flt_reg <= avg_fault[gi];
          seen_reg <= 1'b1;
        end
      end
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          int_reg <= 8'h00;
          frac_reg <= 2'h0;
        end
        else if (!frozen)
        begin
          int_reg <= fmt[9:2]; // RULE2 RULE8 RULE11
          frac_reg <= fmt[1:0]; // RULE7 RULE11
        end
      end
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pend_reg <= 1'b0;
        else if (arm)
          pend_reg <= 1'b1; // RULE11
        else if (rd_ch[gi])
          pend_reg <= 1'b0; // RULE11
      end
      assign int_bus[gi*8 +: 8] = int_reg;
      assign frac_bus[gi*2 +: 2] = frac_reg;
      assign flt_bus[gi] = flt_reg;
      assign seen_bus[gi] = seen_reg;
      assign pend_bus[gi] = pend_reg;
    end
  endgenerate

  // named views of the channel slices
  wire [7:0] int_local = int_bus[8*`DTR_CH_LOCAL +: 8];
  wire [7:0] int_rem1 = int_bus[8*`DTR_CH_REM1 +: 8];
  wire [7:0] int_rem2 = int_bus[8*`DTR_CH_REM2 +: 8];
  wire [1:0] frac_local = frac_bus[2*`DTR_CH_LOCAL +: 2];
  wire [1:0] frac_rem1 = frac_bus[2*`DTR_CH_REM1 +: 2];
  wire [1:0] frac_rem2 = frac_bus[2*`DTR_CH_REM2 +: 2];
  wire flt_local = flt_bus[`DTR_CH_LOCAL];
  wire flt_rem1 = flt_bus[`DTR_CH_REM1];
  wire flt_rem2 = flt_bus[`DTR_CH_REM2];
  wire seen_local = seen_bus[`DTR_CH_LOCAL];
  wire seen_rem1 = seen_bus[`DTR_CH_REM1];
  wire seen_rem2 = seen_bus[`DTR_CH_REM2];

  // shared fraction register, one bit pair per channel
  reg [7:0] ext_val;

  always @*
  begin
    ext_val = 8'h00;
    ext_val[`DTR_EXT_REM1_LSB +: 2] = frac_rem1; // RULE7
    ext_val[`DTR_EXT_LOCAL_LSB +: 2] = frac_local; // RULE7
    ext_val[`DTR_EXT_REM2_LSB +: 2] = frac_rem2; // RULE7
  end

  // status: frozen flag, then fault and have-result bits in address order
  reg [7:0] stat_val;

  always @*
  begin
    stat_val = 8'h00;
    stat_val[`DTR_STAT_FRZ_BIT] = frozen;
    stat_val[`DTR_STAT_FLT_LSB +: 3] = {flt_rem2, flt_local, flt_rem1};
    stat_val[`DTR_STAT_VLD_LSB +: 3] = {seen_rem2, seen_local, seen_rem1};
  end

  reg [7:0] rd_mux;

  always @*
  begin
    case (idx)
      `DTR_IDX_REM1: rd_mux = int_rem1; // RULE8
      `DTR_IDX_LOCAL: rd_mux = int_local; // RULE2
      `DTR_IDX_REM2: rd_mux = int_rem2; // RULE8
      `DTR_IDX_EXT: rd_mux = ext_val; // RULE7
      `DTR_IDX_CFG: rd_mux = cfg_reg;
      `DTR_IDX_STAT: rd_mux = stat_val;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data captured in the setup cycle, held through the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_rd)
      prdata <= mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
  end

  // configuration write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_reg <= `DTR_CFG_RST;
    else if (acc_ph && pwrite && !bad && hit_cfg)
      cfg_reg <= {6'h00, pwdata[`DTR_CFG_RUN_BIT:`DTR_CFG_FMT_BIT]}; // RULE3 RULE12
  end

endmodule

`default_nettype wire

// [dtr_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.vh"
module dtr_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic [1:0] exc_sel
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
  property p_ro;
    psel && penable && pwrite && paddr == 12'h098 |-> pslverr;
  endproperty
  a_ro: assert property (p_ro)
    else $error("write to result byte not refused");
  property p_ext_ok;
    psel && penable && !pwrite && paddr == 12'h1dc |-> !pslverr;
  endproperty
  a_ext_ok: assert property (p_ext_ok)
    else $error("fraction read refused");
  property p_local_off;
    conv_chan == `DTR_CH_LOCAL |-> exc_sel == `DTR_EXC_OFF;
  endproperty
  a_local_off: assert property (p_local_off)
    else $error("excitation on during local channel");
  property p_n1;
    $changed(exc_sel) && exc_sel == `DTR_EXC_N1 |-> $past(exc_sel) == `DTR_EXC_BASE;
  endproperty
  a_n1: assert property (p_n1)
    else $error("first multiple not after base");
  property p_n2;
    $changed(exc_sel) && exc_sel == `DTR_EXC_N2 |-> $past(exc_sel) == `DTR_EXC_BASE;
  endproperty
  a_n2: assert property (p_n2)
    else $error("second multiple not after base");
  property p_hold;
    $changed(exc_sel) && exc_sel != `DTR_EXC_OFF |=> $stable(exc_sel) [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("excitation phase too short");
  property p_start;
    conv_start |-> exc_sel == `DTR_EXC_OFF ##1 !conv_start;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion start malformed");
  property p_chan;
    conv_chan != 2'h3;
  endproperty
  a_chan: assert property (p_chan)
    else $error("illegal channel");
endmodule
bind dtr_top dtr_top_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .conv_start(conv_start),
  .conv_chan(conv_chan),
  .exc_sel(exc_sel)
);
`default_nettype wire

// [tb_dtr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_dtr_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic adc_valid = 1'b0;
  logic [9:0] adc_data = 10'h000;
  logic adc_fault = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire conv_start;
  wire [1:0] conv_chan;
  wire [1:0] exc_sel;
  logic [9:0] smp [0:2];
  logic tgl [0:2];
  logic flt [0:2];
  logic [2:0] dly = 3'd0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int compares = 0;
  always #5 pclk = ~pclk;
  dtr_top dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .conv_start(conv_start),
    .conv_chan(conv_chan),
    .exc_sel(exc_sel),
    .adc_valid(adc_valid),
    .adc_data(adc_data),
    .adc_fault(adc_fault)
  );
  // converter: samples alternate one quarter above and below the set value
  always @(posedge pclk)
  begin
    adc_valid <= 1'b0;
    if (conv_start)
      dly <= 3'd3;
    else if (dly != 3'd0)
    begin
      dly <= dly - 3'd1;
      if (dly == 3'd1)
      begin
        adc_valid <= 1'b1;
        adc_data <= smp[conv_chan] + (tgl[conv_chan] ? 10'h001 : 10'h3ff);
        adc_fault <= flt[conv_chan];
        tgl[conv_chan] <= !tgl[conv_chan];
      end
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        chk("pready", 32'h0, 32'h1);
        conclude();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rd, {24'h0, exp});
  endtask
  task automatic wait_for(input logic [7:0] idx, input logic [7:0] exp);
    int n = 0;
    apb(1'b0, idx, 32'h0);
    while (rd !== {24'h0, exp})
    begin
      n++;
      if (n > 15000)
      begin
        chk("poll", rd, {24'h0, exp});
        conclude();
      end
      apb(1'b0, idx, 32'h0);
    end
  endtask
  task automatic t_regs();
    rchk(8'h7d, 8'h02);
    apb(1'b1, 8'h26, 32'hff);
    chk("ro write", err, 1'b1);
    apb(1'b1, 8'h77, 32'hff);
    chk("ro write", err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
  endtask
  task automatic t_twos();
    wait_for(8'h27, 8'h80);
    rchk(8'h77, 8'h20);
    rchk(8'h25, 8'he7);
    rchk(8'h26, 8'h19);
    rchk(8'h27, 8'h80);
  endtask
  task automatic t_freeze();
    smp[0] <= 10'h029;
    rchk(8'h77, 8'h20);
    apb(1'b0, 8'h25, 32'h0);
    apb(1'b0, 8'h27, 32'h0);
    repeat (28000) @(posedge pclk);
    apb(1'b0, 8'h7e, 32'h0);
    chk("frozen", rd & 32'h1, 32'h1);
    rchk(8'h26, 8'h19);
    apb(1'b0, 8'h7e, 32'h0);
    chk("thawed", rd & 32'h1, 32'h0);
  endtask
  task automatic t_ofs();
    apb(1'b1, 8'h7d, 32'h3);
    chk("cfg write", err, 1'b0);
    wait_for(8'h26, 8'h4a);
    wait_for(8'h25, 8'h27);
    wait_for(8'h27, 8'h00);
    rchk(8'h77, 8'h10);
    rchk(8'h25, 8'h27);
    rchk(8'h26, 8'h4a);
    rchk(8'h27, 8'h00);
  endtask
  initial
  begin
    smp[0] = 10'h066;
    smp[1] = 10'h39c;
    smp[2] = 10'h000;
    tgl[0] = 1'b0;
    tgl[1] = 1'b0;
    tgl[2] = 1'b0;
    flt[0] = 1'b0;
    flt[1] = 1'b0;
    flt[2] = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_twos();
    t_freeze();
    t_ofs();
    conclude();
  end
endmodule
`default_nettype wire
